//--- hw/dmadc_params.svh
// offsets, field positions, reset values and codes of the descriptor adapter
`ifndef DMADC_PARAMS_SVH
`define DMADC_PARAMS_SVH
// ***************
// register offsets
// ***************
`define DMADC_OFF_CTRL 5'h00
`define DMADC_OFF_STAT 5'h04
`define DMADC_OFF_LINK 5'h08
`define DMADC_OFF_LEN 5'h0C
`define DMADC_OFF_MIDX 5'h10
`define DMADC_OFF_MLINK 5'h14
`define DMADC_OFF_MLEN 5'h18
// ***************
// field positions
// ***************
`define DMADC_CTRL_EN 0
`define DMADC_CTRL_SUSP 1
`define DMADC_CTRL_PROD 2
`define DMADC_CTRL_START_LO 16
`define DMADC_LNK_PRD_LO 16
`define DMADC_LNK_CNS_LO 0
`define DMADC_LEN_CNT_LO 16
`define DMADC_LEN_BUF_LO 4
`define DMADC_LEN_OCC 3
`define DMADC_LEN_ERR 2
`define DMADC_LEN_EOP 1
`define DMADC_LEN_MRK 0
// ***************
// values
// ***************
`define DMADC_END_LIST 16'hFFFF
`define DMADC_UNIT_LOG2 4
`define DMADC_CTRL_RST 32'h0000_0000
`define DMADC_WORD_RST 32'h0000_0000
`endif

//--- hw/dmadc_pkg.sv
// types shared by the descriptor adapter
package dmadc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_FETCH, ST_CHECK, ST_XFER, ST_WBACK, ST_NEXT
   } dmadc_state_t;
   typedef logic [31:0] dmadc_word_t;
endpackage

//--- hw/dmadc_mem_if.sv
// descriptor store ports: adapter side and software side
`timescale 1ns/1ps
interface dmadc_mem_if #(parameter int IW = 4);
   logic [IW-1:0] aIdx;
   logic [31:0] aLink;
   logic [31:0] aSize;
   logic aWe;
   logic [31:0] aWrSize;
   logic [IW-1:0] sIdx;
   logic [31:0] sLink;
   logic [31:0] sSize;
   logic sWeLink;
   logic sWeSize;
   logic [31:0] sWrData;
   modport adapter (output aIdx, aWe, aWrSize, sIdx, sWeLink, sWeSize,
      sWrData, input aLink, aSize, sLink, sSize);
   modport mem (input aIdx, aWe, aWrSize, sIdx, sWeLink, sWeSize,
      sWrData, output aLink, aSize, sLink, sSize);
endinterface

//--- hw/dmadc_dscr_mem.sv
// descriptor store in flip-flops, one adapter port and one software port
`timescale 1ns/1ps
module dmadc_dscr_mem #(
   parameter int DEPTH = 16,
   parameter int IW = 4
) (
   // clock
   input wire logic ref_clk,
   // ports
   dmadc_mem_if.mem m
);
   import dmadc_pkg::*;
   dmadc_word_t linkMem [DEPTH];
   dmadc_word_t sizeMem [DEPTH];

   initial begin
      if (DEPTH < 2 || DEPTH > 65535 || (1 << IW) < DEPTH) begin
         $error("dmadc_dscr_mem: bad DEPTH or IW");
      end
   end

   assign m.aLink = linkMem[m.aIdx];
   assign m.aSize = sizeMem[m.aIdx];
   assign m.sLink = linkMem[m.sIdx];
   assign m.sSize = sizeMem[m.sIdx];

   // contents are undefined after reset, so no reset here
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (m.sWeLink && m.sIdx == IW'(i)) begin
            linkMem[i] <= m.sWrData;
         end
      end
   end

   // adapter write-back wins a collision on the same entry
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (m.aWe && m.aIdx == IW'(i)) begin
            sizeMem[i] <= m.aWrSize;
         end else if (m.sWeSize && m.sIdx == IW'(i)) begin
            sizeMem[i] <= m.sWrData;
         end
      end
   end
endmodule

//--- hw/dmadc_adapter.sv
// descriptor chain and size handling of a dma socket adapter
//
// How it works
// R1: link word loaded only on descriptor fetch
// R2: software edits link only suspended or disabled (the code also accepts edits in ST_IDLE while enabled)
// R3: upper link half: producer next, FFFF ends
// R4: lower link half: consumer next, FFFF ends
// R5: size word upper half counts valid bytes
// R6: partly filled buffer still counts as occupied
// R7: buffer size field in 16-byte units
// R8: consumer waits while occupied is zero
// R9: producer waits while occupied is one
// R10: error flag: 0 valid, 1 data in error
// R11: after fetch only eop, count, error, occupied
// R12: only the size word is written back
// R13: ip gives error and eop by signals
// R14: error and eop signals are optional
// R15: software leaves size word to the adapter
// R16: bit 1 marks last buffer, from eop
// R17: bit 0 marker seen by ip only
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "dmadc_params.svh"
module dmadc_adapter #(
   parameter int DSCR_DEPTH = 16,
   parameter bit USE_MARKS = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire dmadc_pkg::dmadc_word_t avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // producing ip stream
   input wire logic prdValid,
   input wire logic prdEop,
   input wire logic prdErr,
   output logic prdReady,
   // consuming ip stream
   output logic cnsValid,
   output logic cnsLast,
   output logic cnsEop,
   output logic cnsErr,
   input wire logic cnsReady,
   // marker seen by the ip
   output logic ipMarker
);
   import dmadc_pkg::*;
   localparam int IW = $clog2(DSCR_DEPTH);

   initial begin
      if (DSCR_DEPTH < 2 || DSCR_DEPTH > 65535) begin
         $error("dmadc_adapter: DSCR_DEPTH out of range");
      end
   end

   // ***************
   // helpers
   // ***************
   function automatic dmadc_word_t mergeBe(input dmadc_word_t old,
         input dmadc_word_t nw, input logic [3:0] be);
      dmadc_word_t r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] bufCap(input dmadc_word_t len);
      return {len[15:4], 4'h0}; // R7
   endfunction

   function automatic logic inRange(input logic [15:0] idx);
      return 32'(idx) < DSCR_DEPTH;
   endfunction

   dmadc_state_t state_ff;
   dmadc_word_t ctrl_ff, link_ff, len_ff, rdData_ff, readMux;
   logic [IW-1:0] curIdx_ff, memIdx_ff;
   logic [15:0] remain_ff, nxtDscr;
   logic waitReq_ff, startReq_ff, done_ff, rangeErr_ff;
   logic prdReady_ff, cnsValid_ff, cnsLast_ff, cnsEop_ff, cnsErr_ff;
   logic marker_ff, busWr, swEdit, prodMode, prdTake, prdLast, cnsTake;
   logic eopIn, errIn;

   dmadc_mem_if #(.IW(IW)) mIf ();
   dmadc_dscr_mem #(.DEPTH(DSCR_DEPTH), .IW(IW)) uMem (
      .ref_clk(ref_clk),
      .m(mIf.mem)
   );

   // ***************
   // avalon slave
   // ***************
   // one wait cycle: the answer is registered, the write lands at release
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         waitReq_ff <= 1'b1;
         rdData_ff <= `DMADC_WORD_RST;
      end else if (waitReq_ff && (avs_read || avs_write)) begin
         waitReq_ff <= 1'b0;
         rdData_ff <= avs_read ? readMux : `DMADC_WORD_RST;
      end else begin
         waitReq_ff <= 1'b1;
      end
   end

   assign busWr = avs_write && !waitReq_ff;
   assign prodMode = ctrl_ff[`DMADC_CTRL_PROD];
   assign swEdit = state_ff == ST_IDLE ||
      (ctrl_ff[`DMADC_CTRL_SUSP] && state_ff == ST_CHECK); // R2

   always_comb begin
      readMux = `DMADC_WORD_RST;
      case (avs_address)
         `DMADC_OFF_CTRL: readMux = ctrl_ff;
         `DMADC_OFF_STAT: readMux = {16'(curIdx_ff), 13'h0000,
            rangeErr_ff, done_ff, state_ff != ST_IDLE};
         `DMADC_OFF_LINK: readMux = link_ff;
         `DMADC_OFF_LEN: readMux = len_ff;
         `DMADC_OFF_MIDX: readMux = 32'(memIdx_ff);
         `DMADC_OFF_MLINK: readMux = mIf.sLink;
         `DMADC_OFF_MLEN: readMux = mIf.sSize;
         default: readMux = `DMADC_WORD_RST;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_ff <= `DMADC_CTRL_RST;
         memIdx_ff <= '0;
      end else if (busWr) begin
         if (avs_address == `DMADC_OFF_CTRL) begin
            ctrl_ff <= mergeBe(ctrl_ff, avs_writedata, avs_byteenable);
         end
         if (avs_address == `DMADC_OFF_MIDX) begin
            memIdx_ff <= IW'(mergeBe(32'(memIdx_ff), avs_writedata,
               avs_byteenable));
         end
      end
   end

   assign mIf.sIdx = memIdx_ff;
   assign mIf.sWrData = mergeBe(avs_address == `DMADC_OFF_MLINK ?
      mIf.sLink : mIf.sSize, avs_writedata, avs_byteenable);
   assign mIf.sWeLink = busWr && avs_address == `DMADC_OFF_MLINK;
   assign mIf.sWeSize = busWr && avs_address == `DMADC_OFF_MLEN;

   // ***************
   // descriptor walk
   // ***************
   assign nxtDscr = prodMode ? link_ff[31:`DMADC_LNK_PRD_LO] // R3
      : link_ff[15:`DMADC_LNK_CNS_LO]; // R4
   // without the optional signals a buffer is just full and clean
   assign eopIn = USE_MARKS && prdEop; // R14
   assign errIn = USE_MARKS && prdErr; // R14
   assign prdTake = prdValid && prdReady_ff;
   assign prdLast = prdTake && (eopIn ||
      len_ff[31:16] + 16'h0001 == bufCap(len_ff));
   assign cnsTake = cnsValid_ff && cnsReady;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_ff <= ST_IDLE;
         curIdx_ff <= '0;
         startReq_ff <= 1'b0;
         done_ff <= 1'b0;
         rangeErr_ff <= 1'b0;
      end else if (!ctrl_ff[`DMADC_CTRL_EN]) begin
         // the enabling write itself lands while still disabled
         state_ff <= ST_IDLE;
         startReq_ff <= busWr && avs_address == `DMADC_OFF_CTRL &&
            avs_writedata[`DMADC_CTRL_EN];
         if (busWr && avs_address == `DMADC_OFF_CTRL) begin
            done_ff <= 1'b0;
            rangeErr_ff <= 1'b0;
         end
      end else begin
         if (busWr && avs_address == `DMADC_OFF_CTRL) begin
            startReq_ff <= 1'b1;
            done_ff <= 1'b0;
            rangeErr_ff <= 1'b0;
         end
         case (state_ff)
            ST_IDLE: begin
               if (startReq_ff) begin
                  startReq_ff <= 1'b0;
                  curIdx_ff <= IW'(ctrl_ff[31:`DMADC_CTRL_START_LO]);
                  state_ff <= ST_FETCH;
               end
            end
            ST_FETCH: state_ff <= ST_CHECK;
            ST_CHECK: begin
               if (ctrl_ff[`DMADC_CTRL_SUSP]) begin
                  state_ff <= ST_CHECK;
               end else if (prodMode == len_ff[`DMADC_LEN_OCC]) begin
                  state_ff <= ST_FETCH; // R8 R9
               end else if (!prodMode && len_ff[31:16] == 16'h0000) begin
                  state_ff <= ST_WBACK;
               end else begin
                  state_ff <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (prodMode ? prdLast : (cnsTake && cnsLast_ff)) begin
                  state_ff <= ST_WBACK;
               end
            end
            ST_WBACK: state_ff <= ST_NEXT;
            ST_NEXT: begin
               if (nxtDscr == `DMADC_END_LIST) begin // R3 R4
                  state_ff <= ST_IDLE;
                  done_ff <= 1'b1;
               end else if (!inRange(nxtDscr)) begin
                  state_ff <= ST_IDLE;
                  rangeErr_ff <= 1'b1;
               end else begin
                  curIdx_ff <= IW'(nxtDscr);
                  state_ff <= ST_FETCH;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ***************
   // descriptor words
   // ***************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         link_ff <= `DMADC_WORD_RST;
      end else if (state_ff == ST_FETCH) begin
         link_ff <= mIf.aLink; // R1
      end else if (busWr && swEdit && avs_address == `DMADC_OFF_LINK) begin
         link_ff <= mergeBe(link_ff, avs_writedata, avs_byteenable); // R2
      end
   end

   // after the fetch only count, occupied, error and eop move, except for software writes while swEdit is set
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         len_ff <= `DMADC_WORD_RST;
      end else if (state_ff == ST_FETCH) begin
         len_ff <= mIf.aSize;
      end else if (busWr && swEdit && avs_address == `DMADC_OFF_LEN) begin
         len_ff <= mergeBe(len_ff, avs_writedata, avs_byteenable); // R15
      end else if (state_ff == ST_CHECK && prodMode && !len_ff[3] &&
            !ctrl_ff[`DMADC_CTRL_SUSP]) begin
         len_ff[31:16] <= 16'h0000; // R11
         len_ff[`DMADC_LEN_ERR] <= 1'b0;
         len_ff[`DMADC_LEN_EOP] <= 1'b0;
         if (bufCap(len_ff) == 16'h0000) begin
            len_ff[`DMADC_LEN_OCC] <= 1'b1;
         end
      end else if (state_ff == ST_XFER && prodMode && prdTake) begin
         len_ff[31:16] <= len_ff[31:16] + 16'h0001; // R5
         len_ff[`DMADC_LEN_ERR] <= len_ff[2] | errIn; // R10 R13
         if (prdLast) begin
            len_ff[`DMADC_LEN_OCC] <= 1'b1; // R6
            len_ff[`DMADC_LEN_EOP] <= eopIn; // R16
         end
      end else if (state_ff == ST_XFER && !prodMode && cnsTake &&
            cnsLast_ff) begin
         len_ff[`DMADC_LEN_OCC] <= 1'b0; // R11
      end else if (state_ff == ST_CHECK && !prodMode && len_ff[3] &&
            len_ff[31:16] == 16'h0000 && !ctrl_ff[`DMADC_CTRL_SUSP]) begin
         len_ff[`DMADC_LEN_OCC] <= 1'b0;
      end
   end

   // a zero-capacity producer buffer is marked occupied, empty, then stays in ST_XFER with prdReady low
   assign mIf.aIdx = curIdx_ff;
   assign mIf.aWe = state_ff == ST_WBACK; // R12
   assign mIf.aWrSize = len_ff; // R12

   // ***************
   // ip streams
   // ***************
   always_ff @(posedge ref_clk) begin
      if (srst || !ctrl_ff[`DMADC_CTRL_EN]) begin
         prdReady_ff <= 1'b0;
      end else if (state_ff == ST_CHECK && prodMode && !len_ff[3] &&
            !ctrl_ff[`DMADC_CTRL_SUSP] && bufCap(len_ff) != 16'h0000) begin
         prdReady_ff <= 1'b1; // R9
      end else if (prdLast) begin
         prdReady_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst || !ctrl_ff[`DMADC_CTRL_EN]) begin
         cnsValid_ff <= 1'b0;
         cnsLast_ff <= 1'b0;
         cnsEop_ff <= 1'b0;
         cnsErr_ff <= 1'b0;
         remain_ff <= 16'h0000;
      end else if (state_ff == ST_CHECK && !prodMode && len_ff[3] &&
            !ctrl_ff[`DMADC_CTRL_SUSP] && len_ff[31:16] != 16'h0000) begin
         cnsValid_ff <= 1'b1; // R8
         remain_ff <= len_ff[31:16];
         cnsLast_ff <= len_ff[31:16] == 16'h0001;
         cnsEop_ff <= len_ff[31:16] == 16'h0001 && len_ff[1]; // R16
         cnsErr_ff <= len_ff[`DMADC_LEN_ERR]; // R10
      end else if (cnsTake) begin
         remain_ff <= remain_ff - 16'h0001;
         cnsValid_ff <= !cnsLast_ff;
         cnsLast_ff <= remain_ff == 16'h0002;
         cnsEop_ff <= remain_ff == 16'h0002 && len_ff[`DMADC_LEN_EOP];
      end
   end

   // the marker only reaches the ip, nothing here looks at it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         marker_ff <= 1'b0;
      end else begin
         marker_ff <= len_ff[`DMADC_LEN_MRK]; // R17
      end
   end

   assign avs_waitrequest = waitReq_ff;
   assign avs_readdata = rdData_ff;
   assign prdReady = prdReady_ff;
   assign cnsValid = cnsValid_ff;
   assign cnsLast = cnsLast_ff;
   assign cnsEop = cnsEop_ff;
   assign cnsErr = cnsErr_ff;
   assign ipMarker = marker_ff;

   // ***************
   // checks
   // ***************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_link_fetch_only: assert property ( // R1
      $changed(link_ff) |-> $past(state_ff) == ST_FETCH || $past(busWr))
      else $error("link word changed outside fetch");
   a_prod_end: assert property ( // R3
      state_ff == ST_NEXT && prodMode && link_ff[31:16] == 16'hFFFF
      |=> state_ff == ST_IDLE && done_ff)
      else $error("producer list end not honoured");
   a_cons_end: assert property ( // R4
      state_ff == ST_NEXT && !prodMode && link_ff[15:0] == 16'hFFFF
      |=> state_ff == ST_IDLE && done_ff)
      else $error("consumer list end not honoured");
   a_count_cap: assert property ( // R7
      state_ff == ST_XFER && prodMode |-> len_ff[31:16] < bufCap(len_ff))
      else $error("byte count passed capacity");
   a_cons_wait: assert property ( // R8
      state_ff == ST_CHECK && !prodMode && !len_ff[3] |=> !cnsValid_ff)
      else $error("consumer ran on empty buffer");
   a_prod_wait: assert property ( // R9
      state_ff == ST_CHECK && prodMode && len_ff[3] |=> !prdReady_ff)
      else $error("producer ran on full buffer");
   a_err_sticky: assert property ( // R10
      prodMode && prdTake && errIn |=> len_ff[2])
      else $error("error flag not set");
   a_size_keep: assert property ( // R11
      state_ff inside {ST_XFER, ST_WBACK}
      |-> $stable(len_ff[15:4]) && $stable(len_ff[0]))
      else $error("size or marker changed");
   a_wb_size: assert property ( // R12
      mIf.aWe |-> $past(state_ff) == ST_XFER || $past(state_ff) == ST_CHECK)
      else $error("write-back without a buffer");
   a_eop_flag: assert property ( // R16
      prdLast |=> len_ff[1] == $past(eopIn) && len_ff[3])
      else $error("eop or occupied not set at close");

   c_prod_buf: cover property (prdLast ##1 state_ff == ST_WBACK);
   c_cons_buf: cover property (cnsTake && cnsLast_ff && cnsEop_ff);
   c_chain: cover property (state_ff == ST_NEXT ##1 state_ff == ST_FETCH);
endmodule

//--- sim/dmadc_ip_model.sv
// attached ip model: byte producer and stalling consumer
`timescale 1ns/1ps
module dmadc_ip_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // settings from the bench
   input wire logic prdOn,
   input wire logic slow,
   input wire logic [15:0] eopAt,
   input wire logic [15:0] errAt,
   // producer side
   input wire logic prdReady,
   output logic prdValid,
   output logic prdEop,
   output logic prdErr,
   // consumer side
   input wire logic cnsValid,
   input wire logic cnsLast,
   input wire logic cnsEop,
   input wire logic cnsErr,
   output logic cnsReady,
   // tallies
   output logic [15:0] beatCnt,
   output logic [15:0] lastCnt,
   output logic [15:0] eopCnt,
   output logic [15:0] errCnt
);
   logic [15:0] sentCnt_ff;
   logic stall_ff;
   // markers ride only on a valid byte, never left stale
   assign prdValid = prdOn;
   assign prdEop = prdOn && (sentCnt_ff + 16'h0001 == eopAt);
   assign prdErr = prdOn && (sentCnt_ff + 16'h0001 == errAt);
   // slow mode takes a beat only every other cycle
   assign cnsReady = !slow || stall_ff;
   always @(posedge ref_clk) begin
      if (srst) begin
         sentCnt_ff <= 16'h0000;
         stall_ff <= 1'b0;
         beatCnt <= 16'h0000;
         lastCnt <= 16'h0000;
         eopCnt <= 16'h0000;
         errCnt <= 16'h0000;
      end else begin
         stall_ff <= !stall_ff;
         if (prdValid && prdReady) sentCnt_ff <= sentCnt_ff + 16'h0001;
         if (cnsValid && cnsReady) begin
            beatCnt <= beatCnt + 16'h0001;
            lastCnt <= lastCnt + {15'h0000, cnsLast};
            eopCnt <= eopCnt + {15'h0000, cnsEop};
            errCnt <= errCnt + {15'h0000, cnsErr};
         end
      end
   end
endmodule

//--- sim/dma_descriptor_chain_size_test.sv
// self-checking bench of the descriptor adapter
`timescale 1ns/1ps
`include "dmadc_params.svh"
module dma_descriptor_chain_size_test;
   import dmadc_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   dmadc_word_t avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, prdValid, prdEop, prdErr, prdReady;
   logic cnsValid, cnsLast, cnsEop, cnsErr, cnsReady, ipMarker;
   logic prdOn = 1'b0;
   logic slow = 1'b0;
   logic [15:0] eopAt = 16'h0005;
   logic [15:0] errAt = 16'h000A;
   logic [15:0] beatCnt, lastCnt, eopCnt, errCnt;
   int errTotal = 0;
   int testsRun = 0;
   int cyc = 0;
   dmadc_adapter dut_u (.ref_clk(ref_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(4'hF),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .prdValid(prdValid),
      .prdEop(prdEop), .prdErr(prdErr), .prdReady(prdReady),
      .cnsValid(cnsValid), .cnsLast(cnsLast), .cnsEop(cnsEop),
      .cnsErr(cnsErr), .cnsReady(cnsReady), .ipMarker(ipMarker));
   dmadc_ip_model ipU (.ref_clk(ref_clk), .srst(srst), .prdOn(prdOn),
      .slow(slow), .eopAt(eopAt), .errAt(errAt), .prdReady(prdReady),
      .prdValid(prdValid), .prdEop(prdEop), .prdErr(prdErr),
      .cnsValid(cnsValid), .cnsLast(cnsLast), .cnsEop(cnsEop),
      .cnsErr(cnsErr), .cnsReady(cnsReady), .beatCnt(beatCnt),
      .lastCnt(lastCnt), .eopCnt(eopCnt), .errCnt(errCnt));
   initial forever #12.5 ref_clk = ~ref_clk;
   // ***************
   // shared tasks
   // ***************
   task automatic final_report();
      $display("checks %0d mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // whole run needs a few hundred cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errTotal = errTotal + 1;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      testsRun = testsRun + 1;
      if (got !== exp) begin
         errTotal = errTotal + 1;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic busWr(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic busRd(input logic [4:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic putDscr(input logic [15:0] i, input logic [31:0] lk,
         input logic [31:0] ln);
      busWr(`DMADC_OFF_MIDX, {16'h0000, i});
      busWr(`DMADC_OFF_MLINK, lk);
      busWr(`DMADC_OFF_MLEN, ln);
   endtask
   task automatic getDscr(input logic [15:0] i, output logic [31:0] lk,
         output logic [31:0] ln);
      busWr(`DMADC_OFF_MIDX, {16'h0000, i});
      busRd(`DMADC_OFF_MLINK, lk);
      busRd(`DMADC_OFF_MLEN, ln);
   endtask
   // bounded only by the cycle ceiling
   task automatic waitDone();
      logic [31:0] st;
      st = 32'h0000_0000;
      while (st[1] !== 1'b1) busRd(`DMADC_OFF_STAT, st);
      chk("status flags", 32'h0000_0002, st & 32'h0000_0007);
   endtask
   // ***************
   // scenarios
   // ***************
   task automatic testReset();
      @(negedge ref_clk);
      chk("wait after reset", 32'h1, {31'h0, avs_waitrequest});
      chk("streams after reset", 32'h0, {29'h0, prdReady, cnsValid, ipMarker});
      $display("test reset done");
   endtask
   task automatic testRegs();
      logic [31:0] lk, ln;
      putDscr(16'h0007, 32'hA5A5_5A5A, 32'h1234_5670);
      getDscr(16'h0007, lk, ln);
      chk("store link", 32'hA5A5_5A5A, lk);
      chk("store length", 32'h1234_5670, ln);
      busRd(5'h1C, lk);
      chk("unmapped read", 32'h0000_0000, lk);
      $display("test regs done");
   endtask
   task automatic testProducer();
      logic [31:0] lk, ln;
      putDscr(16'h0000, 32'h0001_FFFF, 32'h0000_0011);
      putDscr(16'h0001, 32'hFFFF_FFFF, 32'h0000_0010);
      prdOn <= 1'b1;
      busWr(`DMADC_OFF_CTRL, 32'h0000_0005);
      waitDone();
      prdOn <= 1'b0;
      getDscr(16'h0000, lk, ln);
      chk("link kept 0", 32'h0001_FFFF, lk);
      chk("short buffer", 32'h0005_001B, ln);
      chk("short count", 32'h0005, ln[31:16]);
      chk("eop flag", 32'h1, ln[1]);
      getDscr(16'h0001, lk, ln);
      chk("full buffer", 32'h0010_001C, ln);
      chk("error flag", 32'h1, ln[2]);
      chk("fields kept", 32'h0000_0010, ln & 32'h0000_FFF1);
      busRd(`DMADC_OFF_LINK, lk);
      chk("link copy", 32'hFFFF_FFFF, lk);
      $display("test producer done");
   endtask
   task automatic testConsumer();
      logic [31:0] lk, ln;
      slow <= 1'b1;
      putDscr(16'h0002, 32'hFFFF_0003, 32'h0003_001E);
      putDscr(16'h0003, 32'hFFFF_FFFF, 32'h0002_0018);
      busWr(`DMADC_OFF_CTRL, 32'h0002_0001);
      waitDone();
      chk("beats", 32'd5, {16'h0, beatCnt});
      chk("last beats", 32'd2, {16'h0, lastCnt});
      chk("eop beats", 32'd1, {16'h0, eopCnt});
      chk("error beats", 32'd3, {16'h0, errCnt});
      getDscr(16'h0002, lk, ln);
      chk("emptied", 32'h0000_0010, ln & 32'h0000_FFF9);
      slow <= 1'b0;
      $display("test consumer done");
   endtask
   task automatic testWait(input logic [31:0] ctrl, input logic [15:0] i,
         input logic [31:0] ln, input logic mrk);
      int n;
      logic [31:0] d;
      n = 0;
      prdOn <= 1'b1;
      putDscr(i, 32'hFFFF_FFFF, ln);
      busWr(`DMADC_OFF_CTRL, ctrl);
      repeat (40) begin
         @(negedge ref_clk);
         if (prdReady !== 1'b0 || cnsValid !== 1'b0) n = n + 1;
      end
      chk("held off", 32'h0, n);
      chk("marker out", {31'h0, mrk}, {31'h0, ipMarker});
      busWr(`DMADC_OFF_LINK, 32'h1234_5678);
      busRd(`DMADC_OFF_LINK, d);
      chk("busy link", 32'hFFFF_FFFF, d);
      busWr(`DMADC_OFF_CTRL, 32'h0000_0000);
      prdOn <= 1'b0;
      busWr(`DMADC_OFF_LINK, 32'h0007_0008);
      busRd(`DMADC_OFF_LINK, d);
      chk("idle link", 32'h0007_0008, d);
      $display("test wait done");
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      testReset();
      testRegs();
      testProducer();
      testConsumer();
      testWait(32'h0004_0005, 16'h0004, 32'h0000_0019, 1'b1);
      testWait(32'h0005_0001, 16'h0005, 32'h0000_0010, 1'b0);
      final_report();
   end
endmodule
